//--- logic/ulm_pkg.sv
package ulm_pkg;

    // register byte offsets
    localparam logic [7:0] ULM_OFF_STATUS = 8'h00;
    localparam logic [7:0] ULM_OFF_CTRL = 8'h04;
    localparam logic [7:0] ULM_OFF_LINK = 8'h08;
    localparam logic [7:0] ULM_OFF_ROLE = 8'h0C;

    // status flag positions
    localparam int ULM_BIT_ERROR = 0;
    localparam int ULM_BIT_RESUME = 1;
    localparam int ULM_BIT_INCOMPLETE = 2;
    localparam int ULM_BIT_ACK = 3;
    localparam int ULM_BIT_NYET = 4;
    localparam int ULM_BIT_STALL = 5;
    localparam int ULM_NUM_FLAGS = 6;

    // control field positions
    localparam int ULM_CTRL_MODE_LSB = 0;
    localparam int ULM_CTRL_DEV_LPM_EN = 4;
    localparam int ULM_CTRL_REMOTE_WAKE = 5;
    localparam int ULM_CTRL_HOST_LS_LSB = 8;

    // reset values and counts
    localparam logic [2:0] ULM_MODE_RESET = 3'h0;
    localparam logic [3:0] ULM_LINK_RESET = 4'h0;
    localparam logic [1:0] ULM_MAX_ATTEMPTS = 2'h3;
    localparam logic [3:0] ULM_LS_SLEEP_ONE = 4'h1;

    // operating mode selection
    typedef enum logic [2:0] {
        ULM_ROLE_FULL_OTG = 3'h0,
        ULM_ROLE_FORCED_HOST = 3'h1,
        ULM_ROLE_FORCED_HOST_BUS_POWER_WATCH = 3'h2,
        ULM_ROLE_FORCED_DEVICE = 3'h3,
        ULM_ROLE_FORCED_DEVICE_BUS_POWER_WATCH = 3'h4
    } ulm_mode_t;

    // resolved role report
    typedef enum logic [3:0] {
        ULM_RESOLVED_NO_ROLE = 4'h0,
        ULM_RESOLVED_A_SIDE_HOST = 4'h1,
        ULM_RESOLVED_A_SIDE_DEVICE = 4'h2,
        ULM_RESOLVED_B_SIDE_HOST = 4'h3,
        ULM_RESOLVED_B_SIDE_DEVICE = 4'h4,
        ULM_RESOLVED_DUAL_HOST = 4'h5,
        ULM_RESOLVED_DUAL_DEVICE = 4'h6,
        ULM_RESOLVED_DUAL_NONE = 4'h7
    } ulm_role_t;

    // lpm transaction reply
    typedef enum logic [1:0] {
        ULM_REPLY_NONE = 2'h0,
        ULM_REPLY_ACK = 2'h1,
        ULM_REPLY_NYET = 2'h2,
        ULM_REPLY_STALL = 2'h3
    } ulm_reply_t;

    // host side lpm outcome from the protocol engine
    typedef struct packed {
        logic done;
        logic bus_error;
        logic bad_response;
        ulm_reply_t reply;
    } ulm_host_result_t;

    // device side received lpm token
    typedef struct packed {
        logic valid;
        logic [3:0] link_state;
        logic remote_wake;
    } ulm_dev_token_t;

endpackage : ulm_pkg

//--- logic/ulm_lpm_status.sv
`timescale 1ns/1ps
module ulm_lpm_status
    import ulm_pkg::*;
#(
    parameter bit OTG_CAPABLE = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic is_host,
    input wire ulm_host_result_t host_result,
    output logic host_retry,
    output logic [3:0] host_link_state,
    output logic host_remote_wake,
    input wire ulm_dev_token_t dev_token,
    input wire logic tx_fifo_pending,
    output ulm_reply_t dev_reply,
    output logic lpm_suspend,
    input wire logic resume_done,
    input wire logic vbus_pin,
    input wire logic id_pin,
    input wire logic session_active,
    output logic bus_power_droop,
    output logic host_disconnect,
    output ulm_role_t resolved_role
);

    // pin synchronisers
    logic [1:0] vbus_sync_reg;
    logic [1:0] id_sync_reg;
    logic vbus_s;
    logic id_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vbus_sync_reg <= 2'h0;
            id_sync_reg <= 2'h3;
        end else begin
            vbus_sync_reg <= {vbus_sync_reg[0], vbus_pin};
            id_sync_reg <= {id_sync_reg[0], id_pin};
        end
    end
    assign vbus_s = vbus_sync_reg[1];
    assign id_s = id_sync_reg[1];

    // control state
    logic [2:0] mode_reg;
    logic dev_lpm_en_reg;
    logic host_wake_reg;
    logic [3:0] host_ls_reg;
    logic [ULM_NUM_FLAGS-1:0] flags_reg;
    logic [ULM_NUM_FLAGS-1:0] flags_set;
    logic [3:0] rx_ls_reg;
    logic rx_wake_reg;
    logic [1:0] attempt_reg;

    // ahb address phase capture
    logic dp_valid_reg;
    logic dp_write_reg;
    logic [7:0] dp_addr_reg;
    logic wr_ctrl;
    logic rd_status;
    logic addr_ok;

    // only whole aligned words inside the map are decoded
    assign addr_ok = (haddr[31:4] == 28'h0) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_reg <= 1'b0;
            dp_write_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
        end else begin
            dp_valid_reg <= hsel && hready && htrans[1] && addr_ok;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
        end
    end

    assign wr_ctrl = dp_valid_reg && dp_write_reg && (dp_addr_reg == ULM_OFF_CTRL);
    // status read is taken in the address phase so data and clear line up
    assign rd_status = hsel && hready && htrans[1] && !hwrite && addr_ok
        && (haddr[7:0] == ULM_OFF_STATUS);

    // control register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= ULM_MODE_RESET;
            dev_lpm_en_reg <= 1'b0;
            host_wake_reg <= 1'b0;
            host_ls_reg <= ULM_LS_SLEEP_ONE;
        end else if (wr_ctrl) begin
            mode_reg <= hwdata[ULM_CTRL_MODE_LSB +: 3];
            dev_lpm_en_reg <= hwdata[ULM_CTRL_DEV_LPM_EN];
            host_wake_reg <= hwdata[ULM_CTRL_REMOTE_WAKE];
            host_ls_reg <= hwdata[ULM_CTRL_HOST_LS_LSB +: 4];
        end
    end

    // device reply decision
    logic link_ok;
    ulm_reply_t reply_now;
    assign link_ok = (dev_token.link_state == ULM_LS_SLEEP_ONE);

    always_comb begin
        reply_now = ULM_REPLY_NONE;
        if (!is_host && dev_token.valid) begin
            if (!dev_lpm_en_reg) begin
                reply_now = ULM_REPLY_NYET;
            end else if (!link_ok) begin
                reply_now = ULM_REPLY_STALL;
            end else if (tx_fifo_pending) begin
                reply_now = ULM_REPLY_NYET;
            end else begin
                reply_now = ULM_REPLY_ACK;
            end
        end
    end

    logic host_fail;
    assign host_fail = is_host && host_result.done
        && (host_result.bad_response || host_result.reply == ULM_REPLY_NONE);

    // event sources into flags
    always_comb begin
        flags_set = '0;
        flags_set[ULM_BIT_RESUME] = resume_done;
        if (is_host && host_result.done) begin
            flags_set[ULM_BIT_ERROR] = host_result.bus_error;
            flags_set[ULM_BIT_INCOMPLETE] = host_fail && (attempt_reg == ULM_MAX_ATTEMPTS - 2'h1);
            if (!host_result.bad_response) begin
                flags_set[ULM_BIT_ACK] = host_result.reply == ULM_REPLY_ACK;
                flags_set[ULM_BIT_NYET] = host_result.reply == ULM_REPLY_NYET;
                flags_set[ULM_BIT_STALL] = host_result.reply == ULM_REPLY_STALL;
            end
        end
        if (reply_now != ULM_REPLY_NONE) begin
            flags_set[ULM_BIT_ERROR] = dev_lpm_en_reg && !link_ok;
            flags_set[ULM_BIT_INCOMPLETE] = dev_lpm_en_reg && link_ok && tx_fifo_pending;
            flags_set[ULM_BIT_ACK] = reply_now == ULM_REPLY_ACK;
            flags_set[ULM_BIT_NYET] = !dev_lpm_en_reg;
            flags_set[ULM_BIT_STALL] = reply_now == ULM_REPLY_STALL;
        end
    end

    // sticky flags, cleared by a status read, set wins
    genvar gi;
    generate
        for (gi = 0; gi < ULM_NUM_FLAGS; gi++) begin : g_flag
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    flags_reg[gi] <= 1'b0;
                end else if (flags_set[gi]) begin
                    flags_reg[gi] <= 1'b1;
                end else if (rd_status) begin
                    flags_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // host retry counting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            attempt_reg <= 2'h0;
            host_retry <= 1'b0;
        end else begin
            host_retry <= 1'b0;
            if (is_host && host_result.done) begin
                if (host_fail && attempt_reg != ULM_MAX_ATTEMPTS - 2'h1) begin
                    attempt_reg <= attempt_reg + 2'h1;
                    host_retry <= 1'b1;
                end else begin
                    attempt_reg <= 2'h0;
                end
            end
        end
    end

    // device token capture, reply and suspend
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_ls_reg <= ULM_LINK_RESET;
            rx_wake_reg <= 1'b0;
            dev_reply <= ULM_REPLY_NONE;
            lpm_suspend <= 1'b0;
        end else begin
            dev_reply <= reply_now;
            if (!is_host && dev_token.valid) begin
                rx_ls_reg <= dev_token.link_state;
                rx_wake_reg <= dev_token.remote_wake;
            end
            if (reply_now == ULM_REPLY_ACK) begin
                lpm_suspend <= 1'b1;
            end else if (resume_done) begin
                lpm_suspend <= 1'b0;
            end
        end
    end

    // link state and remote wake driven to the host engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_link_state <= ULM_LS_SLEEP_ONE;
            host_remote_wake <= 1'b0;
        end else begin
            host_link_state <= host_ls_reg;
            host_remote_wake <= host_wake_reg;
        end
    end

    // vbus watching by mode
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_power_droop <= 1'b0;
            host_disconnect <= 1'b0;
        end else begin
            bus_power_droop <= 1'b0;
            host_disconnect <= 1'b0;
            case (mode_reg)
                ULM_ROLE_FULL_OTG: begin
                    bus_power_droop <= !id_s && !vbus_s;
                    host_disconnect <= id_s && !vbus_s;
                end
                ULM_ROLE_FORCED_HOST_BUS_POWER_WATCH: begin
                    bus_power_droop <= !vbus_s;
                end
                ULM_ROLE_FORCED_DEVICE_BUS_POWER_WATCH: begin
                    host_disconnect <= !vbus_s;
                end
                default: begin
                end
            endcase
        end
    end

    // role resolution
    ulm_role_t role_next;
    always_comb begin
        role_next = ULM_RESOLVED_NO_ROLE;
        if (OTG_CAPABLE && mode_reg == ULM_ROLE_FULL_OTG) begin
            if (!session_active) begin
                role_next = ULM_RESOLVED_NO_ROLE;
            end else if (!id_s) begin
                role_next = is_host ? ULM_RESOLVED_A_SIDE_HOST : ULM_RESOLVED_A_SIDE_DEVICE;
            end else begin
                role_next = is_host ? ULM_RESOLVED_B_SIDE_HOST : ULM_RESOLVED_B_SIDE_DEVICE;
            end
        end else begin
            case (mode_reg)
                ULM_ROLE_FORCED_HOST, ULM_ROLE_FORCED_HOST_BUS_POWER_WATCH: begin
                    role_next = ULM_RESOLVED_DUAL_HOST;
                end
                ULM_ROLE_FORCED_DEVICE, ULM_ROLE_FORCED_DEVICE_BUS_POWER_WATCH: begin
                    role_next = ULM_RESOLVED_DUAL_DEVICE;
                end
                default: begin
                    role_next = ULM_RESOLVED_DUAL_NONE;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resolved_role <= ULM_RESOLVED_NO_ROLE;
        end else begin
            resolved_role <= role_next;
        end
    end

    // read data, registered in the address phase for zero-wait answers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata <= 32'h0;
            if (addr_ok) begin
                case (haddr[7:0])
                    ULM_OFF_STATUS: hrdata <= {26'h0, flags_reg};
                    ULM_OFF_CTRL: hrdata <= {20'h0, host_ls_reg, 2'h0, host_wake_reg, dev_lpm_en_reg, 1'h0, mode_reg};
                    ULM_OFF_LINK: hrdata <= {27'h0, is_host ? host_wake_reg : rx_wake_reg,
                        is_host ? host_ls_reg : rx_ls_reg};
                    ULM_OFF_ROLE: hrdata <= {28'h0, resolved_role};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    // always ready, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // checks
    sequence dev_nyet_s;
        !is_host && dev_token.valid && !dev_lpm_en_reg;
    endsequence

    sequence dev_ack_s;
        !is_host && dev_token.valid && dev_lpm_en_reg && link_ok && !tx_fifo_pending;
    endsequence

    nyet_flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dev_nyet_s |=> flags_reg[ULM_BIT_NYET] && dev_reply == ULM_REPLY_NYET)
        else $error("nyet flag missing");
    ack_suspend_a: assert property (@(posedge hclk) disable iff (!hresetn)
        dev_ack_s |=> lpm_suspend && flags_reg[ULM_BIT_ACK])
        else $error("ack did not suspend");
    stall_error_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!is_host && dev_token.valid && dev_lpm_en_reg && !link_ok)
        |=> flags_reg[ULM_BIT_ERROR] && flags_reg[ULM_BIT_STALL] && rx_ls_reg == $past(dev_token.link_state))
        else $error("unsupported state not stalled");
    read_clears_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_status && flags_set == '0 |=> flags_reg == '0)
        else $error("status read did not clear");
    flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        flags_reg[ULM_BIT_RESUME] && !rd_status |=> flags_reg[ULM_BIT_RESUME])
        else $error("flag dropped without read");
    resume_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        resume_done |=> flags_reg[ULM_BIT_RESUME])
        else $error("resume flag missing");
    incomplete_third_a: assert property (@(posedge hclk) disable iff (!hresetn)
        flags_set[ULM_BIT_INCOMPLETE] && is_host |-> attempt_reg == 2'h2)
        else $error("incomplete before third attempt");
    host_reply_a: assert property (@(posedge hclk) disable iff (!hresetn)
        is_host && host_result.done && !host_result.bad_response && host_result.reply == ULM_REPLY_STALL
        |=> flags_reg[ULM_BIT_STALL])
        else $error("host stall flag missing");
    host_ls_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> ##1 host_link_state == $past(hwdata[ULM_CTRL_HOST_LS_LSB +: 4], 2))
        else $error("host link state not sent");
    forced_host_role_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_reg == ULM_ROLE_FORCED_HOST ##1 mode_reg == ULM_ROLE_FORCED_HOST
        |-> resolved_role == ULM_RESOLVED_DUAL_HOST)
        else $error("forced host role wrong");

endmodule : ulm_lpm_status

//--- tb/ulm_peer_model.sv
`timescale 1ns/1ps
module ulm_peer_model
    import ulm_pkg::*;
(
    input wire logic hclk,
    output ulm_host_result_t host_result,
    output ulm_dev_token_t dev_token
);

    // quiet bus at time zero
    initial begin
        host_result = '0;
        dev_token = '0;
    end

    // remote host sends one lpm token; released fields show the inverse, never a stale copy
    task automatic token(input logic [3:0] ls, input logic rw);
        dev_token <= '{valid: 1'b1, link_state: ls, remote_wake: rw};
        @(posedge hclk);
        dev_token <= '{valid: 1'b0, link_state: ~ls, remote_wake: ~rw};
    endtask : token

    // remote device answers an lpm request, promptly or after dly cycles
    task automatic answer(input ulm_reply_t r, input logic berr, input logic bad, input int dly);
        repeat (dly) @(posedge hclk);
        host_result <= '{done: 1'b1, bus_error: berr, bad_response: bad, reply: r};
        @(posedge hclk);
        host_result <= '{done: 1'b0, bus_error: ~berr, bad_response: ~bad, reply: ulm_reply_t'(~r)};
    endtask : answer

endmodule : ulm_peer_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import ulm_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, is_host, tx_fifo_pending, resume_done, vbus_pin, id_pin, session_active;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic hreadyout, hresp, host_retry, host_remote_wake, lpm_suspend, bus_power_droop, host_disconnect;
    logic [3:0] host_link_state, ls;
    ulm_host_result_t host_result;
    ulm_dev_token_t dev_token;
    ulm_reply_t dev_reply;
    ulm_role_t resolved_role;
    int n_mismatch, total_checks, n_retry;
    localparam logic [3:0] ROLE_EXP [5] = '{4'h0, 4'h4, 4'h3, 4'h1, 4'h2};

    ulm_lpm_status ulm_lpm_status_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .is_host(is_host), .host_result(host_result), .host_retry(host_retry),
        .host_link_state(host_link_state), .host_remote_wake(host_remote_wake), .dev_token(dev_token),
        .tx_fifo_pending(tx_fifo_pending), .dev_reply(dev_reply), .lpm_suspend(lpm_suspend),
        .resume_done(resume_done), .vbus_pin(vbus_pin), .id_pin(id_pin), .session_active(session_active),
        .bus_power_droop(bus_power_droop), .host_disconnect(host_disconnect), .resolved_role(resolved_role)
    );

    ulm_peer_model ulm_peer_model_i (.hclk(hclk), .host_result(host_result), .dev_token(dev_token));

    // clock
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // retry pulses counted mid-cycle, clear of the launching edge
    always @(negedge hclk) if (host_retry === 1'b1) n_retry++;

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick

    // one single-word transfer; address held until hready, then data phase until hready
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask : ahb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(n, r, e);
    endtask : rd_chk

    function automatic logic [31:0] ctrl_word(input logic [2:0] m, input logic en, input logic rw,
                                              input logic [3:0] l);
        return {20'h0, l, 2'h0, rw, en, 1'h0, m};
    endfunction : ctrl_word

    // one token from the remote host; the reply stands one cycle, so it is looked at mid-cycle
    task automatic tok(input logic [3:0] l, input logic rw, input string n, input ulm_reply_t e);
        ulm_peer_model_i.token(l, rw);
        @(negedge hclk);
        chk(n, 32'(dev_reply), 32'(e));
        @(posedge hclk);
    endtask : tok

    function automatic logic [31:0] flag(input int b);
        return 32'h1 << b;
    endfunction : flag

    // watchdog
    initial begin
        tick(6000);
        n_mismatch++;
        close_out();
    end

    // main sequence
    initial begin
        {hresetn, hsel, hwrite, is_host, tx_fifo_pending, resume_done, id_pin, session_active} = '0;
        vbus_pin = 1'b1;
        haddr = '0;
        hwdata = '0;
        htrans = '0;
        void'($urandom(32'hB62F));
        tick(6);
        hresetn <= 1'b1;
        tick(1);
        rd_chk("ctrl_rst", ULM_OFF_CTRL, 32'h100);
        rd_chk("st_rst", ULM_OFF_STATUS, 32'h0);
        rd_chk("unmapped", 8'h10, 32'h0);
        // device with lpm not enabled
        wr(ULM_OFF_CTRL, ctrl_word(3'h3, 1'b0, 1'b0, 4'h1));
        rd_chk("ctrl_rw", ULM_OFF_CTRL, 32'h103);
        tok(4'h1, 1'b1, "reply_off", ULM_REPLY_NYET);
        rd_chk("st_off", ULM_OFF_STATUS, flag(ULM_BIT_NYET));
        rd_chk("st_again", ULM_OFF_STATUS, 32'h0);
        // unsupported link states are stalled but captured
        wr(ULM_OFF_CTRL, ctrl_word(3'h3, 1'b1, 1'b0, 4'h1));
        for (int i = 0; i < 2; i++) begin
            ls = (i == 0) ? 4'h0 : 4'($urandom_range(15, 2));
            tok(ls, ls[0], "reply_bad", ULM_REPLY_STALL);
            rd_chk("st_bad", ULM_OFF_STATUS, flag(ULM_BIT_ERROR) | flag(ULM_BIT_STALL));
            rd_chk("link_bad", ULM_OFF_LINK, {27'h0, ls[0], ls});
        end
        // transmit data pending, then clean acknowledge and resume
        tx_fifo_pending <= 1'b1;
        tok(4'h1, 1'b0, "reply_fifo", ULM_REPLY_NYET);
        rd_chk("st_fifo", ULM_OFF_STATUS, flag(ULM_BIT_INCOMPLETE));
        tx_fifo_pending <= 1'b0;
        tok(4'h1, 1'b1, "reply_ack", ULM_REPLY_ACK);
        chk("suspend_on", {31'h0, lpm_suspend}, 32'h1);
        tick($urandom_range(9, 1));
        rd_chk("st_ack", ULM_OFF_STATUS, flag(ULM_BIT_ACK));
        rd_chk("link_dev", ULM_OFF_LINK, 32'h11);
        resume_done <= 1'b1;
        tick(1);
        resume_done <= 1'b0;
        tick(2);
        chk("suspend_off", {31'h0, lpm_suspend}, 32'h0);
        rd_chk("st_resume", ULM_OFF_STATUS, flag(ULM_BIT_RESUME));
        // host: configured link state and remote wake go out
        is_host <= 1'b1;
        ls = 4'($urandom);
        wr(ULM_OFF_CTRL, ctrl_word(3'h1, 1'b0, 1'b1, ls));
        tick(3);
        chk("host_ls", {28'h0, host_link_state}, {28'h0, ls});
        chk("host_rw", {31'h0, host_remote_wake}, 32'h1);
        rd_chk("link_host", ULM_OFF_LINK, {27'h0, 1'b1, ls});
        for (int i = 0; i < 3; i++) begin
            ulm_peer_model_i.answer(ulm_reply_t'(i + 1), 1'b0, 1'b0, $urandom_range(3, 0));
            tick(2);
            rd_chk("st_reply", ULM_OFF_STATUS, flag(ULM_BIT_ACK + i));
        end
        // three failed attempts, first with a bus error
        n_retry = 0;
        ulm_peer_model_i.answer(ULM_REPLY_NONE, 1'b1, 1'b0, 0);
        ulm_peer_model_i.answer(ULM_REPLY_NONE, 1'b0, 1'b1, $urandom_range(4, 2));
        ulm_peer_model_i.answer(ULM_REPLY_NONE, 1'b0, 1'b0, $urandom_range(4, 2));
        tick(3);
        chk("retries", 32'(n_retry), 32'h2);
        rd_chk("st_fail", ULM_OFF_STATUS, flag(ULM_BIT_ERROR) | flag(ULM_BIT_INCOMPLETE));
        // forced modes: id ignored, vbus watched only where selected
        for (int m = 1; m < 5; m++) begin
            for (int v = 0; v < 2; v++) begin
                wr(ULM_OFF_CTRL, ctrl_word(3'(m), 1'b0, 1'b0, 4'h1));
                vbus_pin <= 1'(v);
                id_pin <= 1'($urandom);
                tick(6);
                chk("droop", {31'h0, bus_power_droop}, {31'h0, m == 2 && v == 0});
                chk("disconnect", {31'h0, host_disconnect}, {31'h0, m == 4 && v == 0});
                chk("role_forced", 32'(resolved_role), (m < 3) ? 32'(ULM_RESOLVED_DUAL_HOST) :
                    32'(ULM_RESOLVED_DUAL_DEVICE));
            end
        end
        // otg role resolution from session, id and current role
        vbus_pin <= 1'b1;
        wr(ULM_OFF_CTRL, ctrl_word(3'h0, 1'b0, 1'b0, 4'h1));
        for (int i = 0; i < 5; i++) begin
            session_active <= 1'(5'h1E >> i);
            id_pin <= 1'(5'h07 >> i);
            is_host <= 1'(5'h0C >> i);
            vbus_pin <= 1'(5'h0A >> i);
            tick(6);
            chk("otg_droop", {31'h0, bus_power_droop}, {31'h0, 1'(5'h10 >> i)});
            chk("otg_disc", {31'h0, host_disconnect}, {31'h0, 1'(5'h05 >> i)});
            chk("role_port", 32'(resolved_role), 32'(ROLE_EXP[i]));
            rd_chk("role_reg", ULM_OFF_ROLE, 32'(ROLE_EXP[i]));
        end
        close_out();
    end

endmodule : tb_top
